/* bench/aac_core_model.sv */
// behavioural model of the analog converter core on the far side
`timescale 1ns/1ps

module aac_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic convert,
  input wire logic [11:0] level,
  output logic core_valid,
  output logic [11:0] core_data
);
  logic [2:0] cnt; // cycles spent converting
  logic slow; // alternates short and long conversions

  // answer after 3 or 5 convert cycles, one result pulse each time
  // data lines show garbage outside the result cycle, never a held value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      slow <= 1'b0;
      core_valid <= 1'b0;
      core_data <= 12'h000;
    end else begin
      core_valid <= 1'b0;
      if (convert && !core_valid) begin
        if (cnt == (slow ? 3'h4 : 3'h2)) begin
          core_valid <= 1'b1;
          core_data <= level;
          cnt <= 3'h0;
          slow <= ~slow;
        end else begin
          cnt <= cnt + 3'h1;
          core_data <= ~core_data;
        end
      end else begin
        // idle: show the inverse so a stale read cannot match
        cnt <= 3'h0;
        core_data <= ~level;
      end
    end
  end
endmodule

/* bench/adc_accumulate_average_control_test.sv */
// self-checking bench for the accumulate and average control block
`timescale 1ns/1ps

module adc_accumulate_average_control_test;
  logic pclk, presetn, psel, penable, pwrite, start_event;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, core_valid, sample, convert, irq, e;
  logic [11:0] core_data, level;
  int n_fail, comparisons, n_val, n_smp, n;
  // row: count code, adjust shift, core value, expected result
  typedef struct packed {
    logic [3:0] code;
    logic [2:0] adj;
    logic [11:0] d;
    logic [15:0] r;
  } aac_row_t;
  aac_row_t rows [12];

  aac_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_event(start_event), .core_valid(core_valid),
    .core_data(core_data), .sample(sample), .convert(convert), .irq(irq));

  aac_core_model i_core (.pclk(pclk), .presetn(presetn),
    .convert(convert), .level(level), .core_valid(core_valid),
    .core_data(core_data));

  // 4 ns clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // count delivered results and sampling cycles
  always @(posedge pclk) begin
    if (core_valid === 1'b1) n_val++;
    if (sample === 1'b1) n_smp++;
  end

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] x, input logic [31:0] y);
    comparisons++;
    if (y !== x) begin
      $display("BAD %s expected %h seen %h", nm, x, y);
      n_fail++;
    end
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_fail++;
      test_done;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next setup is not a second assignment now
    @(posedge pclk);
  endtask

  // bounded wait for the interrupt line
  task wt_irq;
    int k;
    for (k = 0; k < 30000 && irq !== 1'b1; k++) @(posedge pclk);
    if (k == 30000) begin
      n_fail++;
      test_done;
    end
  endtask

  initial begin
    {psel, penable, pwrite, start_event, presetn} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    level = 12'h000;
    {n_fail, comparisons, n_val, n_smp} = '0;
    // adjust shifts chosen for a true average where shown
    rows = '{'{4'h0, 3'h0, 12'habc, 16'h0abc},
      '{4'h1, 3'h0, 12'hfff, 16'h1ffe}, '{4'h2, 3'h2, 12'h123, 16'h0123},
      '{4'h3, 3'h3, 12'h800, 16'h0800}, '{4'h4, 3'h0, 12'hfff, 16'hfff0},
      '{4'h5, 3'h0, 12'hfff, 16'hfff0}, '{4'h6, 3'h4, 12'h5a5, 16'h05a5},
      '{4'h7, 3'h0, 12'hfff, 16'hfff0}, '{4'h8, 3'h4, 12'h321, 16'h0321},
      '{4'h9, 3'h1, 12'hfff, 16'h7ff8}, '{4'ha, 3'h4, 12'hfff, 16'h0fff},
      '{4'hb, 3'h3, 12'h456, 16'h0456}};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 8'h18, 32'h1);
    // free running sets, stopped once the averaged result is ready
    foreach (rows[i]) begin
      level <= rows[i].d;
      apb(1'b1, 8'h08, {25'h0, rows[i].adj, rows[i].code});
      apb(1'b1, 8'h14, 32'h3);
      apb(1'b1, 8'h00, 32'h13);
      n_val = 0;
      apb(1'b1, 8'h0c, 32'h1);
      wt_irq;
      chk("samples", (rows[i].code > 4'ha) ? 32'h1 : 32'h1 << rows[i].code,
        n_val);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk("result", {16'h0, rows[i].r}, q);
      $display("row %0d done", i);
    end
    // event start with the event enable set
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h14, 32'h3);
    apb(1'b1, 8'h00, 32'h5);
    level <= 12'h3c3;
    start_event <= 1'b1;
    @(posedge pclk);
    start_event <= 1'b0;
    wt_irq;
    apb(1'b0, 8'h10, 32'h0);
    chk("event result", 32'h3c3, q);
    chk("idle pins", 32'h0, {sample, convert});
    $display("event start done");
    // sampling phase length, default and extended
    for (int s = 0; s < 6; s += 5) begin
      apb(1'b1, 8'h04, s);
      apb(1'b1, 8'h14, 32'h3);
      apb(1'b1, 8'h00, 32'h1);
      n_smp = 0;
      apb(1'b1, 8'h0c, 32'h1);
      wt_irq;
      chk("sample cycles", s + 1, n_smp);
    end
    $display("sampling length done");
    // overrun with several channels, masking and write-one clear
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h14, 32'h3);
    apb(1'b1, 8'h00, 32'h0b);
    apb(1'b1, 8'h0c, 32'h1);
    for (n = 0; n < 50; n++) begin
      apb(1'b0, 8'h14, 32'h0);
      if (q[1] === 1'b1) break;
    end
    chk("overrun flag", 32'h3, q);
    chk("masked irq", 32'h0, irq);
    apb(1'b1, 8'h18, 32'h2);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmasked irq", 32'h1, irq);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h14, 32'h3);
    apb(1'b0, 8'h14, 32'h0);
    chk("flags cleared", 32'h0, q);
    chk("irq cleared", 32'h0, irq);
    // unmapped address is refused
    apb(1'b0, 8'h1c, 32'h0);
    chk("pslverr", 32'h1, e);
    chk("unmapped data", 32'h0, q);
    $display("interrupt and bus done");
    // reset with the sequencer disabled brings the registers back to zero
    apb(1'b1, 8'h08, 32'h7f);
    apb(1'b1, 8'h04, 32'h3);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 4; n++) begin
      apb(1'b0, (n == 3) ? 8'h18 : 8'(n * 4), 32'h0);
      chk("reset value", 32'h0, q);
    end
    chk("reset irq", 32'h0, irq);
    $display("reset done");
    test_done;
  end
endmodule

/* design/aac_consts.svh */
// constants for the accumulate and average converter control
`ifndef AAC_CONSTS_SVH
`define AAC_CONSTS_SVH

// register byte offsets on the apb side
`define AAC_OFS_CTRL 8'h00
`define AAC_OFS_SAMP 8'h04
`define AAC_OFS_AVG 8'h08
`define AAC_OFS_TRIG 8'h0c
`define AAC_OFS_RESULT 8'h10
`define AAC_OFS_FLAG 8'h14
`define AAC_OFS_MASK 8'h18

// control register bit positions
`define AAC_CTRL_EN 0
`define AAC_CTRL_FREE 1
`define AAC_CTRL_EVS 2
`define AAC_CTRL_MULTI 3
`define AAC_CTRL_RES_LO 4
`define AAC_CTRL_RES_HI 5

// average control field positions
`define AAC_AVG_CODE_LO 0
`define AAC_AVG_CODE_HI 3
`define AAC_AVG_ADJ_LO 4
`define AAC_AVG_ADJ_HI 6

// sampling length field and trigger bit
`define AAC_SAMP_LEN_HI 5
`define AAC_TRIG_START 0

// flag and mask bit positions
`define AAC_FLAG_RDY 0
`define AAC_FLAG_OVR 1

// widths and limits
`define AAC_ADC_W 12
`define AAC_SUM_W 22
`define AAC_CNT_W 11
`define AAC_RES_W 16
`define AAC_MAX_CODE 10
`define AAC_AUTO_BASE 4

// reset values
`define AAC_RESSEL_RST 2'h0
`define AAC_SAMPLEN_RST 6'h00

`endif

/* design/aac_pkg.sv */
// types shared by the converter control files
`include "aac_consts.svh"

package aac_pkg;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAMP = 3'b010,
    ST_CONV = 3'b100
  } aac_state_t;

  // whole state of the control block
  typedef struct packed {
    aac_state_t st;
    logic en;
    logic free;
    logic evs;
    logic multi;
    logic [1:0] ressel;
    logic [5:0] samplen;
    logic [3:0] code;
    logic [2:0] adj;
    logic pend;
    logic [5:0] samp_cnt;
    logic [`AAC_SUM_W-1:0] sum;
    logic [`AAC_CNT_W-1:0] cnt;
    logic [`AAC_RES_W-1:0] result;
    logic unread;
    logic [1:0] flags;
    logic [1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic sample;
    logic convert;
  } aac_regs_t;

endpackage

/* design/aac_scale.sv */
// sample count decode and final right shift of the running sum
`timescale 1ns/1ps
`include "aac_consts.svh"

module aac_scale (
  input wire logic [`AAC_SUM_W-1:0] sum,
  input wire logic [3:0] code,
  input wire logic [2:0] adj,
  output logic [`AAC_CNT_W-1:0] nsamp,
  output logic [`AAC_RES_W-1:0] res
);

  logic [3:0] k; // effective count code
  logic [3:0] auto_sh; // automatic shift
  logic [3:0] total; // automatic plus adjustment
  logic [`AAC_SUM_W-1:0] shifted;

  // decode code, fold reserved codes to one sample
  always_comb begin
    if (code > 4'(`AAC_MAX_CODE)) begin
      k = 4'h0;
      auto_sh = 4'h0;
      total = 4'h0;
    end else begin
      k = code;
      // above sixteen samples the sum must still fit 16 bits
      auto_sh = (code > 4'(`AAC_AUTO_BASE)) ?
        4'(code - 4'(`AAC_AUTO_BASE)) : 4'h0;
      total = 4'(auto_sh + {1'b0, adj});
    end
    nsamp = `AAC_CNT_W'(1) << k;
    shifted = sum >> total;
    res = shifted[`AAC_RES_W-1:0];
  end

endmodule

/* design/aac_top.sv */
// converter start timing, accumulation and averaging control
// Behaviour
// - start by software bit or enabled event
// - default sampling is first half period
// - sampling phase lengthened by sampling length
// - sum two to the code samples, one sample for reserved codes
// - sum precision grows, unshifted up to sixteen
// - above sixteen shift right by code minus four
// - adjustment shift adds to automatic shift
// - final value written to result register
// - one result per configured sample count
// - ready flag only after full count
// - new result replaces old result
// - unread result overwritten with channels sets overrun
// - free running restarts without trigger
`timescale 1ns/1ps
`include "aac_consts.svh"

module aac_top #(
  parameter int ADC_W = `AAC_ADC_W, // core result width
  parameter int MAX_CODE = `AAC_MAX_CODE // highest count code
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_event,
  input wire logic core_valid,
  input wire logic [11:0] core_data,
  output logic sample,
  output logic convert,
  output logic irq
);

  // the struct and the sum are sized for these values only
  generate
    if (ADC_W != `AAC_ADC_W || MAX_CODE != `AAC_MAX_CODE) begin : g_chk
      $error("aac_top: unsupported width or count code");
    end
  endgenerate

  aac_pkg::aac_regs_t r_reg; // registered state
  aac_pkg::aac_regs_t r_next; // next state

  logic acc_wr; // write access phase
  logic acc_rd; // read access phase
  logic setup; // setup phase
  logic [`AAC_SUM_W-1:0] new_sum; // sum with incoming sample
  logic [`AAC_CNT_W-1:0] nsamp; // samples per result
  logic [`AAC_RES_W-1:0] scaled; // shifted final value
  logic fin; // this sample completes the set
  logic trig_wr; // software start written this cycle

  // running sum including the sample now arriving
  assign new_sum = r_reg.sum + `AAC_SUM_W'(core_data);
  assign fin = (r_reg.cnt + `AAC_CNT_W'(1)) == nsamp;

  // count decode and output shift
  aac_scale u_scale (
    .sum(new_sum),
    .code(r_reg.code),
    .adj(r_reg.adj),
    .nsamp(nsamp),
    .res(scaled)
  );

  // bus phase decode; the answer is ready in the first access cycle
  assign setup = psel & ~penable;
  assign acc_wr = psel & penable & pwrite & r_reg.pready;
  assign acc_rd = psel & penable & ~pwrite & r_reg.pready;
  assign trig_wr = acc_wr && paddr == `AAC_OFS_TRIG &&
    pwdata[`AAC_TRIG_START];

  // next state of the whole block
  always_comb begin
    r_next = r_reg;

    // bus answer, prepared during setup
    r_next.pready = setup;
    r_next.pslverr = 1'b0;
    r_next.prdata = 32'h0;
    if (setup) begin
      unique case (paddr)
        `AAC_OFS_CTRL: begin
          r_next.prdata[`AAC_CTRL_EN] = r_reg.en;
          r_next.prdata[`AAC_CTRL_FREE] = r_reg.free;
          r_next.prdata[`AAC_CTRL_EVS] = r_reg.evs;
          r_next.prdata[`AAC_CTRL_MULTI] = r_reg.multi;
          r_next.prdata[`AAC_CTRL_RES_HI:`AAC_CTRL_RES_LO] = r_reg.ressel;
        end
        `AAC_OFS_SAMP: begin
          r_next.prdata[`AAC_SAMP_LEN_HI:0] = r_reg.samplen;
        end
        `AAC_OFS_AVG: begin
          r_next.prdata[`AAC_AVG_CODE_HI:`AAC_AVG_CODE_LO] = r_reg.code;
          r_next.prdata[`AAC_AVG_ADJ_HI:`AAC_AVG_ADJ_LO] = r_reg.adj;
        end
        `AAC_OFS_TRIG: begin
          // trigger reads back as pending start
          r_next.prdata[`AAC_TRIG_START] = r_reg.pend;
        end
        `AAC_OFS_RESULT: begin
          r_next.prdata[`AAC_RES_W-1:0] = r_reg.result;
        end
        `AAC_OFS_FLAG: begin
          r_next.prdata[1:0] = r_reg.flags;
        end
        `AAC_OFS_MASK: begin
          r_next.prdata[1:0] = r_reg.mask;
        end
        default: begin
          // unmapped: error answer, no effect
          r_next.pslverr = 1'b1;
        end
      endcase
    end

    // register writes take effect in the access cycle
    if (acc_wr) begin
      unique case (paddr)
        `AAC_OFS_CTRL: begin
          r_next.en = pwdata[`AAC_CTRL_EN];
          r_next.free = pwdata[`AAC_CTRL_FREE];
          r_next.evs = pwdata[`AAC_CTRL_EVS];
          r_next.multi = pwdata[`AAC_CTRL_MULTI];
          // is kept by software; stored only
          r_next.ressel = pwdata[`AAC_CTRL_RES_HI:`AAC_CTRL_RES_LO];
        end
        `AAC_OFS_SAMP: begin
          r_next.samplen = pwdata[`AAC_SAMP_LEN_HI:0];
        end
        `AAC_OFS_AVG: begin
          r_next.code = pwdata[`AAC_AVG_CODE_HI:`AAC_AVG_CODE_LO];
          // is kept by software choosing this value
          r_next.adj = pwdata[`AAC_AVG_ADJ_HI:`AAC_AVG_ADJ_LO];
        end
        `AAC_OFS_TRIG: begin
          if (pwdata[`AAC_TRIG_START]) begin
            r_next.pend = 1'b1;
          end
        end
        `AAC_OFS_FLAG: begin
          // write one to clear; a same-cycle set below still wins
          r_next.flags = r_reg.flags & ~pwdata[1:0];
        end
        `AAC_OFS_MASK: begin
          r_next.mask = pwdata[1:0];
        end
        default: begin
          // unmapped write ignored
          r_next.pslverr = 1'b0;
        end
      endcase
    end

    // reading the result marks it consumed
    if (acc_rd && paddr == `AAC_OFS_RESULT) begin
      r_next.unread = 1'b0;
    end

    // conversion sequencer
    unique case (r_reg.st)
      aac_pkg::ST_IDLE: begin
        // a request registered one cycle earlier starts here
        if (r_reg.en && (r_reg.pend || r_reg.free)) begin
          r_next.st = aac_pkg::ST_SAMP;
          r_next.pend = 1'b0;
          r_next.samp_cnt = r_reg.samplen;
        end
      end
      aac_pkg::ST_SAMP: begin
        // one pclk is the first half of a conversion period
        if (r_reg.samp_cnt == 6'h00) begin
          r_next.st = aac_pkg::ST_CONV;
        end else begin
          r_next.samp_cnt = r_reg.samp_cnt - 6'h01;
        end
      end
      aac_pkg::ST_CONV: begin
        if (core_valid) begin
          if (fin) begin
            // whole set summed and shifted: publish it
            r_next.result = scaled;
            r_next.sum = `AAC_SUM_W'(0);
            r_next.cnt = `AAC_CNT_W'(0);
            r_next.flags[`AAC_FLAG_RDY] = 1'b1;
            if (r_reg.unread && r_reg.multi) begin
              r_next.flags[`AAC_FLAG_OVR] = 1'b1;
            end
            r_next.unread = 1'b1;
          end else begin
            // partial set: keep summing, no result yet
            r_next.sum = new_sum;
            r_next.cnt = r_reg.cnt + `AAC_CNT_W'(1);
          end
          // free running chains the next conversion at once
          if (r_reg.en && (r_reg.free || r_reg.pend)) begin
            r_next.st = aac_pkg::ST_SAMP;
            r_next.pend = 1'b0;
            r_next.samp_cnt = r_reg.samplen;
          end else begin
            r_next.st = aac_pkg::ST_IDLE;
          end
        end
      end
    endcase

    // new requests land after the sequencer has taken the old one,
    // so a start arriving in the same cycle is not lost
    // start event is honoured only while enabled for it
    if (trig_wr || (start_event && r_reg.evs)) begin
      r_next.pend = 1'b1;
    end

    // disabling aborts the sequence and drops a partial sum
    if (!r_reg.en) begin
      r_next.st = aac_pkg::ST_IDLE;
      r_next.sum = `AAC_SUM_W'(0);
      r_next.cnt = `AAC_CNT_W'(0);
    end

    // pin outputs follow the next state so they come from flops
    r_next.sample = (r_next.st == aac_pkg::ST_SAMP);
    r_next.convert = (r_next.st == aac_pkg::ST_CONV);
    r_next.irq = |(r_next.flags & r_next.mask);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{
        st: aac_pkg::ST_IDLE,
        ressel: `AAC_RESSEL_RST,
        samplen: `AAC_SAMPLEN_RST,
        default: '0
      };
    end else begin
      r_reg <= r_next;
    end
  end

  // ports straight from the state register
  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign sample = r_reg.sample;
  assign convert = r_reg.convert;
  assign irq = r_reg.irq;

  // helper: length of the current sampling phase, for checking only
  logic [6:0] samp_run;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_run <= 7'h00;
    end else if (sample) begin
      samp_run <= samp_run + 7'h01;
    end else begin
      samp_run <= 7'h00;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a software trigger while idle and enabled starts sampling
  property p_sw_start;
    acc_wr && paddr == `AAC_OFS_TRIG && pwdata[`AAC_TRIG_START] &&
      r_reg.en && r_reg.st == aac_pkg::ST_IDLE |-> ##[1:2] sample;
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("trigger did not start sampling");

  // without extension sampling lasts a single pclk; disabling may cut it
  property p_half;
    $rose(sample) && r_reg.samp_cnt == 6'h00 && r_reg.en |=>
      !sample ##0 convert;
  endproperty
  a_half: assert property (p_half)
    else $error("default sampling not one half period");

  // sampling phase length is samplen plus one cycles
  // a phase cut short by disabling ends without convert
  property p_len;
    $fell(sample) && convert |->
      samp_run == {1'b0, $past(r_reg.samplen)} + 7'h01;
  endproperty
  a_len: assert property (p_len)
    else $error("sampling length wrong");

  // ready flag rises only on the last sample of a set
  property p_rdy_full;
    $rose(r_reg.flags[`AAC_FLAG_RDY]) |->
      $past(fin && core_valid && r_reg.st == aac_pkg::ST_CONV);
  endproperty
  a_rdy_full: assert property (p_rdy_full)
    else $error("ready flag set before full count");

  // thirty-two samples: sum shifted right by one
  property p_auto;
    core_valid && fin && r_reg.st == aac_pkg::ST_CONV && r_reg.en &&
      r_reg.code == 4'h5 && r_reg.adj == 3'h0 |=>
      r_reg.result == $past(new_sum[`AAC_RES_W:1]);
  endproperty
  a_auto: assert property (p_auto)
    else $error("automatic shift wrong");

  // reserved code: every sample is its own unshifted result
  property p_rsvd;
    core_valid && r_reg.st == aac_pkg::ST_CONV && r_reg.en &&
      r_reg.code > 4'ha |=>
      r_reg.result == `AAC_RES_W'($past(core_data)) &&
      r_reg.flags[`AAC_FLAG_RDY];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved code not single sample");

  // eight samples averaged by an adjustment shift of three
  property p_avg;
    core_valid && fin && r_reg.st == aac_pkg::ST_CONV && r_reg.en &&
      r_reg.code == 4'h3 && r_reg.adj == 3'h3 |=>
      r_reg.result == $past(new_sum[14:3]);
  endproperty
  a_avg: assert property (p_avg)
    else $error("average shift wrong");

  // unread result overwritten with several channels sets overrun
  property p_ovr;
    core_valid && fin && r_reg.st == aac_pkg::ST_CONV && r_reg.en &&
      r_reg.unread && r_reg.multi |=> r_reg.flags[`AAC_FLAG_OVR];
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun not flagged");

  // free running goes back to sampling with no trigger
  property p_free;
    core_valid && r_reg.st == aac_pkg::ST_CONV && r_reg.en &&
      r_reg.free |=> sample;
  endproperty
  a_free: assert property (p_free)
    else $error("free running did not restart");

  // scenarios worth seeing
  c_avg16: cover property (r_reg.code == 4'h4 &&
    $rose(r_reg.flags[`AAC_FLAG_RDY]));
  c_ovr: cover property ($rose(r_reg.flags[`AAC_FLAG_OVR]));
  c_ext: cover property ($fell(sample) && samp_run > 7'h03);
  c_irq: cover property ($rose(irq));

endmodule
